// ===== rtl/converter_defines.svh
// Constants shared by the register bank, its serial host and their link.
`ifndef CONVERTER_DEFINES_SVH
`define CONVERTER_DEFINES_SVH

// Serial frame layout.
`define FRAME_BITS 5'd24
`define CMD_BITS 5'd8
`define CMD_RW_POS 7
`define CMD_ADDR_HI 4
`define CMD_ADDR_LO 1
`define CMD_RSVD_PATTERN 2'b10
`define CMD_DONT_CARE 1'b0
`define DATA_MSB 15

// Register addresses.
`define ADDR_CONFIG 4'h0
`define ADDR_I_OFFSET 4'h2
`define ADDR_I_RANGE 4'h3
`define ADDR_TRIM_ADJUST 4'h4
`define ADDR_TRIM_VALUES 4'h5
`define ADDR_INTERLEAVE_TIMING 4'h7
`define ADDR_Q_OFFSET 4'ha
`define ADDR_Q_RANGE 4'hb
`define ADDR_DELAY_COARSE 4'hc
`define ADDR_DELAY_FINE 4'hd
`define ADDR_MULTI_CHIP_SYNC 4'he

// Default values.
`define CONFIG_DEFAULT 16'h2000
`define OTHER_DEFAULT 16'h0000
`define RSVD_READ 16'h0000

// Main configuration field positions.
`define CFG_CAL 15
`define CFG_STROBE_PHASE 14
`define CFG_SWING 13
`define CFG_PATTERN 12
`define CFG_I_SLEEP 11
`define CFG_Q_SLEEP 10
`define CFG_RSVD9 9
`define CFG_TRIM 8
`define CFG_INTERLEAVE 7
`define CFG_INPUT_PICK 6
`define CFG_INPUT_TIE 5

// Host APB register offsets and fields.
`define HOST_CMD_OFF 8'h00
`define HOST_STATUS_OFF 8'h04
`define HOST_RDATA_OFF 8'h08
`define HOST_CTRL_OFF 8'h0c
`define HOST_CMD_READ_POS 8
`define HOST_CTRL_LEAVE_EXT 0
`define HOST_CTRL_CAL_PIN 1

// Serial clock half period in core clocks.
`define SCLK_HALF_DEFAULT 4
`define SCLK_HALF_MIN 3
`define SCLK_HALF_MAX 256

`endif

// ===== rtl/converter_pkg.sv
// Types shared by the register bank and its serial host.
package converter_pkg;
    typedef logic [15:0] reg_word_t;
    typedef logic [23:0] frame_word_t;
    typedef enum logic [3:0] {
        HOST_IDLE = 4'b0001,
        HOST_LOW = 4'b0010,
        HOST_HIGH = 4'b0100,
        HOST_GAP = 4'b1000
    } host_state_e;
endpackage

// ===== rtl/serial_link_if.sv
// Serial register link and mode pins between host and register bank.
`timescale 1ns/1ns
interface serial_link_if;
    logic sclk;
    logic scs_n;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic extended_pin_n;
    logic cal_pin;
    modport dev (
        input sclk,
        input scs_n,
        input sdi,
        output sdo,
        output sdo_oe,
        input extended_pin_n,
        input cal_pin
    );
    modport host (
        output sclk,
        output scs_n,
        output sdi,
        input sdo,
        input sdo_oe,
        output extended_pin_n,
        output cal_pin
    );
endinterface

// ===== rtl/converter_register_bank.sv
// Control register bank of the dual-channel converter, served over the serial link.
//
// Function
// - Outside extended mode registers hold defaults.
// - In extended mode eleven registers are read/write.
// - Four-bit address map with reserved locations.
// - Calibration bit never self-clears after calibration.
// - Calibration request is bit OR pin.
// - Bit 14 picks strobe-to-data phase.
// - Bit 13 picks output swing level.
// - Bit 12 outputs fixed pattern instead samples.
// - I channel sleeps on bit 11 or pin.
// - Q channel sleeps on bit 10 or pin.
// - Bit 8 trim, forced on in saver mode.
// - Bit 7 selects interleaved sampling.
// - Interleaved: bit 6 picks I or Q input.
// - Interleaved: bit 5 ties inputs together.
// - Host writes reserved bit 9 as default.
// - Mode pin high reloads all defaults.
// - One access is one 24-clock frame.
// - Command: read flag, 10b, address, don't-care.
// - Unimplemented address reads as zeros.
//
// The serial link port was chosen for this implementation.
`timescale 1ns/1ns
`include "converter_defines.svh"
module converter_register_bank (
    input wire logic core_clk,
    input wire logic arst_n,
    serial_link_if.dev link,
    input wire logic chan_i_sleep_pin,
    input wire logic chan_q_sleep_pin,
    input wire logic slow_rate_saver,
    output logic extended_control,
    output logic cal_request,
    output logic strobe_phase_select,
    output logic swing_high,
    output logic pattern_out_select,
    output logic chan_i_sleep,
    output logic chan_q_sleep,
    output logic slow_clock_trim,
    output logic interleave_on,
    output logic interleave_input_pick,
    output logic input_tie_select
);

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode helpers.

    function automatic logic is_impl(input logic [3:0] addr);
        case (addr)
            `ADDR_CONFIG, `ADDR_I_OFFSET, `ADDR_I_RANGE, `ADDR_TRIM_ADJUST,
            `ADDR_TRIM_VALUES, `ADDR_INTERLEAVE_TIMING, `ADDR_Q_OFFSET,
            `ADDR_Q_RANGE, `ADDR_DELAY_COARSE, `ADDR_DELAY_FINE,
            `ADDR_MULTI_CHIP_SYNC: is_impl = 1'b1;
            default: is_impl = 1'b0;
        endcase
    endfunction

    function automatic converter_pkg::reg_word_t reg_default(input logic [3:0] addr);
        if (addr == `ADDR_CONFIG) begin
            reg_default = `CONFIG_DEFAULT;
        end else begin
            reg_default = `OTHER_DEFAULT;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Frame reception.

    converter_pkg::reg_word_t regs_q [16];
    converter_pkg::reg_word_t rdata_q;
    logic sclk_prev_q;
    logic [4:0] cnt_q;
    logic [23:0] shift_q;
    logic [7:0] cmd_q;
    logic sdo_q;
    logic sdo_oe_q;

    wire ecm_now = ~link.extended_pin_n;
    wire in_frame = ~link.scs_n;
    wire sclk_rise = link.sclk & ~sclk_prev_q;
    wire sclk_fall = ~link.sclk & sclk_prev_q;
    // Clocks beyond the 24th are ignored until chip select is toggled.
    wire take_bit = in_frame & sclk_rise & (cnt_q != `FRAME_BITS);
    wire [4:0] cnt_inc = cnt_q + 5'd1;
    wire [23:0] shift_next = {shift_q[22:0], link.sdi};
    wire cmd_done = take_bit & (cnt_q == (`CMD_BITS - 5'd1));
    wire frame_end = take_bit & (cnt_q == (`FRAME_BITS - 5'd1));
    wire is_read = cmd_q[`CMD_RW_POS];
    wire [3:0] cmd_addr = cmd_q[`CMD_ADDR_HI:`CMD_ADDR_LO];
    // A frame cut short by chip select never reaches frame_end, so nothing is written.
    wire wr_fire = frame_end & ~is_read & ecm_now & is_impl(cmd_addr);
    wire [15:0] wr_word = shift_next[15:0];
    wire [15:0] rd_value = is_impl(cmd_addr) ? regs_q[cmd_addr] : `RSVD_READ;
    wire drive_start = in_frame & sclk_fall & is_read & (cnt_q == `CMD_BITS);
    wire drive_next = in_frame & sclk_fall & is_read & sdo_oe_q & (cnt_q > `CMD_BITS) & (cnt_q != `FRAME_BITS);
    wire [4:0] out_idx = `FRAME_BITS - 5'd1 - cnt_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_prev_q <= 1'b0;
            cnt_q <= 5'd0;
            shift_q <= 24'h000000;
            cmd_q <= 8'h00;
        end else begin
            sclk_prev_q <= link.sclk;
            if (!in_frame) begin
                cnt_q <= 5'd0;
            end else if (take_bit) begin
                cnt_q <= cnt_inc;
                shift_q <= shift_next;
            end
            if (cmd_done) begin
                cmd_q <= shift_next[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data out; the word is frozen at the 8th falling edge so a concurrent
    // change cannot tear it. After D0 the line holds until chip select rises.

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= `RSVD_READ;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else if (!in_frame) begin
            sdo_oe_q <= 1'b0;
        end else if (drive_start) begin
            rdata_q <= rd_value;
            sdo_q <= rd_value[`DATA_MSB];
            sdo_oe_q <= 1'b1;
        end else if (drive_next) begin
            sdo_q <= rdata_q[out_idx[3:0]];
        end
    end

    assign link.sdo = sdo_q;
    assign link.sdo_oe = sdo_oe_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage.

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 16; i++) begin
                regs_q[i] <= reg_default(4'(i));
            end
        end else if (!ecm_now) begin
            // Held at defaults for as long as the mode pin is high.
            for (int i = 0; i < 16; i++) begin
                regs_q[i] <= reg_default(4'(i));
            end
        end else if (wr_fire) begin
            // The calibration bit is kept as written; nothing clears it here.
            regs_q[cmd_addr] <= wr_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control outputs.

    wire [15:0] cfg = regs_q[`ADDR_CONFIG];
    wire cfg_interleave = cfg[`CFG_INTERLEAVE];
    wire extended_control_d = ecm_now;
    // A pin and its register bit are ORed, so either source alone can request the
    // function, and neither can cancel a request made by the other.
    wire cal_request_d = cfg[`CFG_CAL] | link.cal_pin;
    wire strobe_phase_d = cfg[`CFG_STROBE_PHASE];
    wire swing_high_d = cfg[`CFG_SWING];
    wire pattern_out_d = cfg[`CFG_PATTERN];
    wire chan_i_sleep_d = cfg[`CFG_I_SLEEP] | chan_i_sleep_pin;
    wire chan_q_sleep_d = cfg[`CFG_Q_SLEEP] | chan_q_sleep_pin;
    // The saver input forces the trim on, and the stored bit is then ignored.
    wire slow_clock_trim_d = slow_rate_saver | cfg[`CFG_TRIM];
    wire interleave_on_d = cfg_interleave;
    // Pick and tie only mean something when interleaved, so they are gated here,
    // while the stored bits still read back exactly as written.
    wire input_pick_d = cfg_interleave & cfg[`CFG_INPUT_PICK];
    wire input_tie_d = cfg_interleave & cfg[`CFG_INPUT_TIE];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            extended_control <= 1'b0;
            cal_request <= 1'b0;
            strobe_phase_select <= 1'b0;
            swing_high <= 1'b0;
            pattern_out_select <= 1'b0;
            chan_i_sleep <= 1'b0;
            chan_q_sleep <= 1'b0;
            slow_clock_trim <= 1'b0;
            interleave_on <= 1'b0;
            interleave_input_pick <= 1'b0;
            input_tie_select <= 1'b0;
        end else begin
            extended_control <= extended_control_d;
            cal_request <= cal_request_d;
            strobe_phase_select <= strobe_phase_d;
            swing_high <= swing_high_d;
            pattern_out_select <= pattern_out_d;
            chan_i_sleep <= chan_i_sleep_d;
            chan_q_sleep <= chan_q_sleep_d;
            slow_clock_trim <= slow_clock_trim_d;
            interleave_on <= interleave_on_d;
            interleave_input_pick <= input_pick_d;
            input_tie_select <= input_tie_d;
        end
    end

endmodule

// ===== rtl/converter_serial_host.sv
// Host controller: APB registers in, serial register frames out.
`timescale 1ns/1ns
`include "converter_defines.svh"
module converter_serial_host #(
    parameter int SCLK_HALF = `SCLK_HALF_DEFAULT
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    serial_link_if.host link
);

    // The bank samples the serial clock in this same clock, so each half period
    // must leave it time to see the edge and answer on the data line.
    // The half period counter is eight bits wide, which caps the slowest serial clock.
    if (SCLK_HALF < `SCLK_HALF_MIN || SCLK_HALF > `SCLK_HALF_MAX) begin : g_bad_half
        $error("SCLK_HALF outside the range the register bank and counter can serve");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave with one wait state so every output comes from a flop.

    converter_pkg::host_state_e state_q;
    converter_pkg::frame_word_t tx_q;
    logic [23:0] rx_q;
    logic [15:0] rdata_q;
    logic [4:0] bit_q;
    logic [7:0] half_q;
    logic busy_q;
    logic done_q;
    logic leave_ext_q;
    logic cal_pin_q;
    logic sclk_q;
    logic scs_n_q;
    logic sdi_q;

    wire access = psel & penable;
    wire commit = access & pready;
    wire hit_cmd = paddr == `HOST_CMD_OFF;
    wire hit_status = paddr == `HOST_STATUS_OFF;
    wire hit_rdata = paddr == `HOST_RDATA_OFF;
    wire hit_ctrl = paddr == `HOST_CTRL_OFF;
    wire mapped = hit_cmd | hit_status | hit_rdata | hit_ctrl;
    wire cmd_refused = pwrite & hit_cmd & busy_q;
    wire start = commit & pwrite & hit_cmd & ~busy_q;
    wire [3:0] req_addr = pwdata[3:0];
    wire req_read = pwdata[`HOST_CMD_READ_POS];
    wire [15:0] req_data = (req_addr == `ADDR_CONFIG) ?
        (pwdata[31:16] & ~(16'h0001 << `CFG_RSVD9)) : pwdata[31:16];
    wire [15:0] req_word = req_read ? 16'h0000 : req_data;
    wire [31:0] rd_mux = hit_status ? {30'h00000000, done_q, busy_q} :
                         hit_rdata ? {16'h0000, rdata_q} :
                         hit_ctrl ? {30'h00000000, cal_pin_q, leave_ext_q} : 32'h00000000;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            leave_ext_q <= 1'b0;
            cal_pin_q <= 1'b0;
        end else begin
            pready <= access & ~pready;
            prdata <= rd_mux;
            pslverr <= access & ~pready & (~mapped | cmd_refused);
            if (commit & pwrite & hit_ctrl) begin
                leave_ext_q <= pwdata[`HOST_CTRL_LEAVE_EXT];
                cal_pin_q <= pwdata[`HOST_CTRL_CAL_PIN];
            end
        end
    end

    assign link.extended_pin_n = leave_ext_q;
    assign link.cal_pin = cal_pin_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame engine: data changes while the clock is low, sampled on its rise.

    wire half_end = half_q == 8'(SCLK_HALF - 1);
    wire last_bit = bit_q == (`FRAME_BITS - 5'd1);
    wire [4:0] next_bit = bit_q + 5'd1;
    wire [4:0] next_idx = `FRAME_BITS - 5'd1 - next_bit;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= converter_pkg::HOST_IDLE;
            tx_q <= 24'h000000;
            rx_q <= 24'h000000;
            rdata_q <= 16'h0000;
            bit_q <= 5'd0;
            half_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            sclk_q <= 1'b0;
            scs_n_q <= 1'b1;
            sdi_q <= 1'b0;
        end else begin
            half_q <= half_end ? 8'h00 : half_q + 8'h01;
            case (state_q)
                converter_pkg::HOST_IDLE: begin
                    half_q <= 8'h00;
                    if (start) begin
                        tx_q <= {req_read, `CMD_RSVD_PATTERN, req_addr, `CMD_DONT_CARE, req_word};
                        sdi_q <= req_read;
                        bit_q <= 5'd0;
                        scs_n_q <= 1'b0;
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        state_q <= converter_pkg::HOST_LOW;
                    end
                end
                converter_pkg::HOST_LOW: begin
                    if (half_end) begin
                        sclk_q <= 1'b1;
                        rx_q <= {rx_q[22:0], link.sdo};
                        state_q <= converter_pkg::HOST_HIGH;
                    end
                end
                converter_pkg::HOST_HIGH: begin
                    if (half_end) begin
                        sclk_q <= 1'b0;
                        if (last_bit) begin
                            scs_n_q <= 1'b1;
                            rdata_q <= rx_q[15:0];
                            state_q <= converter_pkg::HOST_GAP;
                        end else begin
                            bit_q <= next_bit;
                            sdi_q <= tx_q[next_idx];
                            state_q <= converter_pkg::HOST_LOW;
                        end
                    end
                end
                converter_pkg::HOST_GAP: begin
                    if (half_end) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= converter_pkg::HOST_IDLE;
                    end
                end
                default: begin
                    state_q <= converter_pkg::HOST_IDLE;
                end
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.scs_n = scs_n_q;
    assign link.sdi = sdi_q;

endmodule

// ===== bench/converter_link_monitor.sv
// Checker for the serial frames between host and register bank.
`timescale 1ns/1ns
module converter_link_monitor #(
    parameter int SCLK_HALF = 4
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic scs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic extended_pin_n,
    input wire logic cal_pin
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////////////
    logic sclk_q, scs_q, rw_q;
    logic [4:0] cnt_q;
    logic [7:0] gap_q;
    wire rise = sclk & ~sclk_q & ~scs_n;

    // The rise count is cleared at frame start, not end, so it still reads 24 while the bank releases sdo.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q <= 1'b0;
            scs_q <= 1'b1;
            rw_q <= 1'b0;
            cnt_q <= 5'h00;
            gap_q <= 8'h00;
        end else begin
            sclk_q <= sclk;
            scs_q <= scs_n;
            if (scs_q && !scs_n) begin
                cnt_q <= 5'h00;
            end else if (rise) begin
                cnt_q <= cnt_q + 5'h01;
            end
            if (rise && cnt_q == 5'h00) begin
                rw_q <= sdi;
            end
            if (!scs_n) begin
                gap_q <= 8'h00;
            end else if (gap_q != 8'hff) begin
                gap_q <= gap_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_frame_exact_count: assert property ($rose(scs_n) |-> cnt_q == 5'h18) else $error("frame not 24 clocks");
    a_cmd_fixed_bits: assert property (rise && (cnt_q == 5'h01 || cnt_q == 5'h02) |-> sdi == (cnt_q == 5'h01))
        else $error("command reserved bits not 10b");
    a_sclk_idle_low: assert property (scs_n && $past(scs_n) |-> !sclk) else $error("sclk runs outside frame");
    a_sdi_stable_high: assert property (!scs_n && sclk && $past(sclk) |-> $stable(sdi))
        else $error("sdi moved while sclk high");
    a_oe_read_only: assert property (sdo_oe |-> rw_q && cnt_q >= 5'h08) else $error("sdo driven outside read data");
    a_oe_start_point: assert property ($rose(sdo_oe) |-> cnt_q == 5'h08 && !sclk) else $error("sdo drive start wrong");
    a_oe_release: assert property ($rose(scs_n) |-> ##[1:3] !sdo_oe) else $error("sdo not released");
    a_gap_min: assert property ($fell(scs_n) |-> gap_q >= SCLK_HALF) else $error("chip select gap short");

    c_read_frame: cover property ($rose(sdo_oe));
    c_write_frame: cover property ($rose(scs_n) && !rw_q);
    c_leave_ext: cover property ($rose(extended_pin_n));
    c_cal_pin: cover property ($rose(cal_pin));
endmodule

// ===== bench/converter_control_register_bank_tb.sv
// Self-checking bench joining the serial host and the register bank.
`timescale 1ns/1ns
module converter_control_register_bank_tb;
    localparam int SCLK_HALF = 3;
    logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, i_pin, q_pin, saver, ext, cal;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    wire [8:0] outs;
    int num_errors = 0;
    int compares = 0;

    serial_link_if link ();
    converter_serial_host #(.SCLK_HALF(SCLK_HALF)) i_converter_serial_host (.core_clk(core_clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.host));
    converter_register_bank i_converter_register_bank (.core_clk(core_clk), .arst_n(arst_n), .link(link.dev),
        .chan_i_sleep_pin(i_pin), .chan_q_sleep_pin(q_pin), .slow_rate_saver(saver), .extended_control(ext),
        .cal_request(cal), .strobe_phase_select(outs[8]), .swing_high(outs[7]), .pattern_out_select(outs[6]),
        .chan_i_sleep(outs[5]), .chan_q_sleep(outs[4]), .slow_clock_trim(outs[3]), .interleave_on(outs[2]),
        .interleave_input_pick(outs[1]), .input_tie_select(outs[0]));
    converter_link_monitor #(.SCLK_HALF(SCLK_HALF)) i_converter_link_monitor (.core_clk(core_clk), .arst_n(arst_n),
        .sclk(link.sclk), .scs_n(link.scs_n), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
        .extended_pin_n(link.extended_pin_n), .cal_pin(link.cal_pin));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    // No cycle count is assumed for the answer; only the bound guards a dead slave.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            $display("[ERR] apb pready expected 1 seen 0");
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic frame(input logic rd, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
        logic [31:0] r;
        logic e;
        int n;
        apb(1'b1, 8'h00, {d, 7'h00, rd, 4'h0, a}, r, e);
        n = 0;
        do begin
            apb(1'b0, 8'h04, 32'h0, r, e);
            n++;
        end while (r[1:0] !== 2'b10 && n < 100);
        if (n >= 100) begin
            num_errors++;
            $display("[ERR] frame status expected 2 seen %h", r[1:0]);
        end
        apb(1'b0, 8'h08, 32'h0, r, e);
        q = r[15:0];
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] q;
        frame(1'b0, a, d, q);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] q;
        frame(1'b1, a, 16'h0000, q);
        chk($sformatf("reg %h", a), {16'h0000, exp}, {16'h0000, q});
    endtask

    task automatic set_ctrl(input logic [1:0] v);
        logic [31:0] r;
        logic e;
        apb(1'b1, 8'h0c, {30'h0, v}, r, e);
        repeat (3) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        rdchk(4'h0, 16'h2000);
        chk_bit("swing", 1'b1, outs[7]);
        chk_bit("extended", 1'b1, ext);
    endtask

    // Locations 1 to 15 are written before any is read back, so aliasing between addresses shows.
    task automatic t_map();
        logic [31:0] r;
        logic e;
        for (int a = 1; a < 16; a++) wr(a[3:0], 16'h5a00 | 16'(a));
        for (int a = 1; a < 16; a++) rdchk(a[3:0], (a inside {1, 6, 8, 9, 15}) ? 16'h0000 : 16'h5a00 | 16'(a));
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk_bit("apb unmapped error", 1'b1, e);
    endtask

    task automatic t_cfg();
        wr(4'h0, 16'h7ce0);
        rdchk(4'h0, 16'h7ce0);
        chk("cfg outs", 32'h1f7, {23'h0, outs});
        wr(4'h0, 16'h0360);
        rdchk(4'h0, 16'h0160);
        chk("cfg outs", 32'h008, {23'h0, outs});
    endtask

    task automatic t_pins();
        wr(4'h0, 16'h0000);
        i_pin <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("pin outs", 32'h020, {23'h0, outs});
        q_pin <= 1'b1;
        saver <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("pin outs", 32'h038, {23'h0, outs});
        i_pin <= 1'b0;
        q_pin <= 1'b0;
        saver <= 1'b0;
    endtask

    task automatic t_cal();
        set_ctrl(2'b10);
        chk_bit("cal pin", 1'b1, cal);
        set_ctrl(2'b00);
        chk_bit("cal idle", 1'b0, cal);
        wr(4'h0, 16'h8000);
        wr(4'h2, 16'h0001);
        chk_bit("cal held", 1'b1, cal);
        rdchk(4'h0, 16'h8000);
        wr(4'h0, 16'h0000);
        chk_bit("cal cleared", 1'b0, cal);
    endtask

    task automatic t_nonext();
        wr(4'h2, 16'h0abc);
        set_ctrl(2'b01);
        chk_bit("extended", 1'b0, ext);
        wr(4'h2, 16'h0123);
        rdchk(4'h2, 16'h0000);
        rdchk(4'h0, 16'h2000);
        set_ctrl(2'b00);
        rdchk(4'h2, 16'h0000);
        wr(4'h2, 16'h0456);
        rdchk(4'h2, 16'h0456);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // About fifty frames of roughly 170 clocks each; the bound leaves ample margin.
    initial begin
        #200000;
        num_errors++;
        $display("[ERR] watchdog expected finish seen timeout");
        summarize();
    end

    initial begin
        {arst_n, psel, penable, pwrite, i_pin, q_pin, saver} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        t_defaults();
        t_map();
        t_cfg();
        t_pins();
        t_cal();
        t_nonext();
        summarize();
    end
endmodule
